// ---- shared/rpfrc_pkg.sv ----
// shared constants and types for the radio phy frame and reset control block
package rpfrc_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned POR_TIME_US   = 3000;
  localparam int unsigned WARM_TIME_US  = 20;
  localparam int unsigned POR_CYCLES    = (POR_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned WARM_CYCLES   = (WARM_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned XTAL_MHZ      = 32;
  localparam int unsigned PREAMBLE_LEN  = 4;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h00;
  localparam logic [7:0]  DELIM_BYTE    = 8'ha7;
  localparam logic [7:0]  LEN_MIN       = 8'h07;
  localparam logic [7:0]  LEN_MAX       = 8'h3f;
  localparam logic [6:0]  CHAN_MAX      = 7'h5f;
  localparam int unsigned CHAN_BASE_MHZ = 2400;
  localparam int unsigned NORMAL_KBPS   = 250;
  localparam int unsigned TURBO_KBPS    = 1000;
  localparam int unsigned NORMAL_BW_MHZ = 2;
  localparam int unsigned TURBO_BW_MHZ  = 8;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned RATE_DIV_NORM = 200;
  localparam int unsigned RATE_DIV_TURB = 50;
  typedef enum logic [2:0] {RPF_HUNT, RPF_PRE, RPF_DELIM, RPF_LEN, RPF_BODY, RPF_SKIP} rpf_rx_e;
  typedef enum logic [1:0] {RPF_POR, RPF_WARM, RPF_RUN} rpf_rst_e;
endpackage : rpfrc_pkg

// ---- shared/rpfrc_stream_if.sv ----
// stream carrier between the framer and its payload fifo
`timescale 1ns/100ps
`default_nettype none
interface rpfrc_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : rpfrc_stream_if
`default_nettype wire

// ---- rtl/rpfrc_fifo.sv ----
// parameterised synchronous fifo with registered read data
`timescale 1ns/100ps
`default_nettype none
module rpfrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  input  wire logic   clr,
  rpfrc_stream_if.snk in_s,
  output logic [WIDTH-1:0] out_data,
  output logic             out_valid,
  input  wire logic        out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic             full, empty, do_wr, do_rd, next_out_valid;
  logic [WIDTH-1:0] next_out_data;

  logic [AW+1:0]    used;
  // the output register counts toward the depth, so no more than DEPTH words are ever held
  assign used        = {1'b0, wr_ptr - rd_ptr} + {{(AW+1){1'b0}}, out_valid};
  assign full        = (used == (AW+2)'(DEPTH));
  assign empty       = (wr_ptr == rd_ptr);
  assign in_s.ready  = !full;
  assign do_wr       = in_s.valid && !full;
  // output register refills whenever it is empty or being taken
  assign do_rd       = !empty && (!out_valid || out_ready);

  always_comb begin
    next_wr_ptr    = clr ? '0 : (do_wr ? wr_ptr + 1'b1 : wr_ptr);
    next_rd_ptr    = clr ? '0 : (do_rd ? rd_ptr + 1'b1 : rd_ptr);
    next_out_data  = do_rd ? mem[rd_ptr[AW-1:0]] : out_data;
    next_out_valid = clr ? 1'b0 : (do_rd ? 1'b1 : (out_ready ? 1'b0 : out_valid));
  end

  always_ff @(posedge ref_clk) begin
    if (do_wr && !clr) begin
      mem[wr_ptr[AW-1:0]] <= in_s.data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      out_data  <= '0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      out_data  <= next_out_data;
      out_valid <= next_out_valid;
    end
  end

  chk_fifo_no_overrun: assert property (@(posedge ref_clk) disable iff (!nrst)
    full |-> !do_wr) else $error("fifo written while full");
endmodule : rpfrc_fifo
`default_nettype wire

// ---- rtl/rpfrc_core.sv ----
// radio phy framer: reset sequencing, spi frame gate, rx header parse, events
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - power-up clears state, ready after 3 ms
// - warm reset input held 20 us after release
// - one spi link carries commands and data
// - interrupt on wake, rx ok, tx done, timeout
// - channel 2400 to 2495 MHz, 1 MHz steps
// - oqpsk dsss at 250 kbps or 1 Mbps
// - turbo keeps mac behaviour, bandwidth 8 MHz
// - header: four preamble, delimiter, length bytes
// - payload length valid from 7 to 63
// - preamble and delimiter sync before length
// - core clock derived from 32 MHz crystal
// - select input frames each spi transaction
module rpfrc_core #(
  parameter int unsigned POR_CYC  = rpfrc_pkg::POR_CYCLES,
  parameter int unsigned WARM_CYC = rpfrc_pkg::WARM_CYCLES,
  parameter int          DEPTH    = rpfrc_pkg::FIFO_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       warm_rst_n_pin,
  input  wire logic       serial_select_in,
  input  wire logic       turbo_mode,
  input  wire logic [6:0] chan_sel,
  input  wire logic       rx_bit_in,
  input  wire logic       wake_evt,
  input  wire logic       tx_done_evt,
  input  wire logic       tx_timeout_evt,
  input  wire logic       irq_ack,
  output logic            ready,
  output logic            spi_frame_active,
  output logic [11:0]     carrier_mhz,
  output logic [3:0]      bandwidth_mhz,
  output logic            sym_tick,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [5:0]      rx_len,
  output logic            rx_len_valid,
  output logic            rx_drop,
  output logic            irq_n
);
  // pin inputs pass two flops before use
  logic [1:0] warm_sync, sel_sync, bit_sync;
  logic       warm_n, sel_n, rx_bit;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      warm_sync <= 2'b11;
      sel_sync  <= 2'b11;
      bit_sync  <= 2'b00;
    end else begin
      warm_sync <= {warm_sync[0], warm_rst_n_pin};
      sel_sync  <= {sel_sync[0], serial_select_in};
      bit_sync  <= {bit_sync[0], rx_bit_in};
    end
  end
  assign warm_n = warm_sync[1];
  assign sel_n  = sel_sync[1];
  assign rx_bit = bit_sync[1];

  // reset sequencer; the pad pull-up lives in the io ring, here an open pin reads high
  rpfrc_pkg::rpf_rst_e rst_st, next_rst_st;
  logic [31:0]         rst_cnt, next_rst_cnt;
  logic                next_ready;
  always_comb begin
    next_rst_st  = rst_st;
    next_rst_cnt = rst_cnt;
    next_ready   = 1'b0;
    case (rst_st)
      rpfrc_pkg::RPF_POR: begin
        next_rst_cnt = rst_cnt + 32'h1;
        if (rst_cnt >= POR_CYC - 1) begin
          next_rst_st  = rpfrc_pkg::RPF_RUN;
          next_rst_cnt = '0;
          next_ready   = warm_n;
        end
      end
      rpfrc_pkg::RPF_WARM: begin
        // counter restarts while the pin is still low
        next_rst_cnt = warm_n ? rst_cnt + 32'h1 : '0;
        if (warm_n && rst_cnt >= WARM_CYC - 1) begin
          next_rst_st  = rpfrc_pkg::RPF_RUN;
          next_rst_cnt = '0;
          next_ready   = 1'b1;
        end
      end
      rpfrc_pkg::RPF_RUN: begin
        next_ready = 1'b1;
      end
      default: next_rst_st = rpfrc_pkg::RPF_POR;
    endcase
    if (!warm_n && rst_st != rpfrc_pkg::RPF_POR) begin
      next_rst_st  = rpfrc_pkg::RPF_WARM;
      next_rst_cnt = '0;
      next_ready   = 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_st  <= rpfrc_pkg::RPF_POR;
      rst_cnt <= '0;
      ready   <= 1'b0;
    end else begin
      rst_st  <= next_rst_st;
      rst_cnt <= next_rst_cnt;
      ready   <= next_ready;
    end
  end
  logic run;
  assign run = (rst_st == rpfrc_pkg::RPF_RUN);

  // spi select gate; transactions while held in reset are ignored
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) spi_frame_active <= 1'b0;
    else       spi_frame_active <= run && !sel_n;
  end

  // channel and rate; out-of-range channel codes clamp to the top channel
  function automatic logic [11:0] chan_to_mhz(input logic [6:0] c);
    logic [6:0] cc;
    cc = (c > rpfrc_pkg::CHAN_MAX) ? rpfrc_pkg::CHAN_MAX : c;
    return 12'(rpfrc_pkg::CHAN_BASE_MHZ) + {5'h00, cc};
  endfunction
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      carrier_mhz   <= 12'(rpfrc_pkg::CHAN_BASE_MHZ);
      bandwidth_mhz <= 4'(rpfrc_pkg::NORMAL_BW_MHZ);
    end else begin
      carrier_mhz   <= chan_to_mhz(chan_sel);
      bandwidth_mhz <= turbo_mode ? 4'(rpfrc_pkg::TURBO_BW_MHZ)
                                  : 4'(rpfrc_pkg::NORMAL_BW_MHZ);
    end
  end

  // bit-rate enable; ref_clk stands for the 50 MHz core clock derived from the 32 MHz crystal
  logic [7:0] div_cnt, next_div_cnt;
  logic       next_sym_tick;
  always_comb begin
    next_sym_tick = 1'b0;
    next_div_cnt  = div_cnt + 8'h1;
    if (div_cnt >= (turbo_mode ? 8'(rpfrc_pkg::RATE_DIV_TURB - 1)
                               : 8'(rpfrc_pkg::RATE_DIV_NORM - 1))) begin
      next_div_cnt  = '0;
      next_sym_tick = run;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt  <= '0;
      sym_tick <= 1'b0;
    end else begin
      div_cnt  <= next_div_cnt;
      sym_tick <= next_sym_tick;
    end
  end

  // bytes assembled lsb first from the despread bit stream
  logic [7:0] sh, next_sh;
  logic [2:0] bcnt, next_bcnt;
  logic       byte_stb, next_byte_stb, bit_stb, align;
  always_comb begin
    next_sh       = sh;
    next_bcnt     = bcnt;
    next_byte_stb = 1'b0;
    if (sym_tick) begin
      next_sh   = {rx_bit, sh[7:1]};
      next_bcnt = bcnt + 3'h1;
      next_byte_stb = (bcnt == 3'h7);
    end
    // a delimiter hit restarts byte counting, the bit stream has no other alignment
    if (align) next_bcnt = '0;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sh <= '0; bcnt <= '0; byte_stb <= 1'b0; bit_stb <= 1'b0;
    end else begin
      sh <= next_sh; bcnt <= next_bcnt; byte_stb <= next_byte_stb; bit_stb <= sym_tick;
    end
  end

  // header parser: preamble, delimiter, length, then payload
  rpfrc_pkg::rpf_rx_e rx_st, next_rx_st;
  logic [5:0]  remain, next_remain;
  logic [5:0]  pcnt, next_pcnt;
  logic        next_len_valid, next_drop, push;
  rpfrc_stream_if #(.W(8)) fin ();
  always_comb begin
    next_rx_st     = rx_st;
    next_remain    = remain;
    next_pcnt      = pcnt;
    next_len_valid = 1'b0;
    next_drop      = 1'b0;
    push           = 1'b0;
    align          = 1'b0;
    if (!run) begin
      next_rx_st = rpfrc_pkg::RPF_HUNT;
      next_pcnt  = '0;
    end else if (bit_stb && (rx_st == rpfrc_pkg::RPF_HUNT || rx_st == rpfrc_pkg::RPF_PRE)) begin
      // preamble counted bit by bit, so no byte alignment is assumed
      if (sh[7] == rpfrc_pkg::PREAMBLE_BYTE[7]) begin
        next_pcnt  = pcnt + 6'h1;
        next_rx_st = rpfrc_pkg::RPF_PRE;
        if (pcnt == 6'(rpfrc_pkg::PREAMBLE_LEN * 8 - 1)) begin
          next_pcnt  = '0;
          next_rx_st = rpfrc_pkg::RPF_DELIM;
        end
      end else begin
        next_pcnt  = '0;
        next_rx_st = rpfrc_pkg::RPF_HUNT;
      end
    end else if (bit_stb && rx_st == rpfrc_pkg::RPF_DELIM) begin
      if (sh == rpfrc_pkg::DELIM_BYTE) begin
        next_rx_st = rpfrc_pkg::RPF_LEN;
        align      = 1'b1;
      end else if (sh == rpfrc_pkg::PREAMBLE_BYTE) begin
        next_pcnt = '0;
      end else begin
        // a delimiter must complete within eight bits of the last preamble window
        next_pcnt = pcnt + 6'h1;
        if (pcnt == 6'h07) next_rx_st = rpfrc_pkg::RPF_HUNT;
      end
    end else if (byte_stb) begin
      case (rx_st)
        rpfrc_pkg::RPF_LEN: begin
          if (sh >= rpfrc_pkg::LEN_MIN && sh <= rpfrc_pkg::LEN_MAX) begin
            next_remain    = sh[5:0];
            next_len_valid = 1'b1;
            next_rx_st     = rpfrc_pkg::RPF_BODY;
          end else begin
            next_drop  = 1'b1;
            next_rx_st = rpfrc_pkg::RPF_HUNT;
          end
        end
        rpfrc_pkg::RPF_BODY: begin
          // a byte arriving into a full fifo is lost; rx_drop flags the overrun
          push        = fin.ready;
          next_drop   = !fin.ready;
          next_remain = remain - 6'h1;
          if (remain == 6'h1) next_rx_st = rpfrc_pkg::RPF_HUNT;
        end
        default: next_rx_st = rx_st;
      endcase
    end
  end
  assign fin.data  = sh;
  assign fin.valid = push;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_st <= rpfrc_pkg::RPF_HUNT; remain <= '0; pcnt <= '0;
      rx_len <= '0; rx_len_valid <= 1'b0; rx_drop <= 1'b0;
    end else begin
      rx_st <= next_rx_st; remain <= next_remain; pcnt <= next_pcnt;
      rx_len_valid <= next_len_valid;
      rx_drop      <= next_drop;
      if (next_len_valid) rx_len <= next_remain;
    end
  end

  rpfrc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .clr       (!run),
    .in_s      (fin),
    .out_data  (rx_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready)
  );

  // interrupt: sticky, set wins over acknowledge
  logic rx_ok, irq_pend, next_irq_pend;
  assign rx_ok = (rx_st == rpfrc_pkg::RPF_BODY) && byte_stb && remain == 6'h1;
  always_comb begin
    next_irq_pend = irq_pend && !irq_ack;
    if (run && (wake_evt || rx_ok || tx_done_evt || tx_timeout_evt)) next_irq_pend = 1'b1;
    if (!run) next_irq_pend = 1'b0;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_pend <= 1'b0; irq_n <= 1'b1;
    end else begin
      irq_pend <= next_irq_pend; irq_n <= !next_irq_pend;
    end
  end

  chk_irq_on_event: assert property (@(posedge ref_clk) disable iff (!nrst)
    run && tx_done_evt && !$past(!run) |=> !irq_n) else $error("no irq after event");
  chk_por_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    rst_st == rpfrc_pkg::RPF_POR |-> !ready) else $error("ready during por");
  chk_warm_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(warm_n) && rst_st == rpfrc_pkg::RPF_WARM |=> !ready [*8]) else $error("warm short");
  chk_warm_enter: assert property (@(posedge ref_clk) disable iff (!nrst)
    !warm_n && rst_st == rpfrc_pkg::RPF_RUN |=> rst_st == rpfrc_pkg::RPF_WARM)
    else $error("warm reset missed");
  chk_sel_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    spi_frame_active |-> $past(run) && !$past(sel_n)) else $error("frame outside select");
  chk_chan_range: assert property (@(posedge ref_clk) disable iff (!nrst)
    carrier_mhz >= 12'd2400 && carrier_mhz <= 12'd2495) else $error("channel range");
  chk_bw_turbo: assert property (@(posedge ref_clk) disable iff (!nrst)
    turbo_mode |=> bandwidth_mhz == 4'h8) else $error("turbo bandwidth");
  chk_len_range: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_len_valid |-> rx_len >= 6'h07 && rx_len <= 6'h3f) else $error("bad length passed");
  chk_bad_len_drop: assert property (@(posedge ref_clk) disable iff (!nrst)
    byte_stb && rx_st == rpfrc_pkg::RPF_LEN && sh < 8'h07 |=> rx_drop && !rx_len_valid)
    else $error("bad length kept");
  chk_sync_first: assert property (@(posedge ref_clk) disable iff (!nrst)
    rx_st == rpfrc_pkg::RPF_LEN |-> $past(rx_st) inside {rpfrc_pkg::RPF_DELIM, rpfrc_pkg::RPF_LEN})
    else $error("length before delimiter");
  chk_turbo_rate: assert property (@(posedge ref_clk) disable iff (!nrst)
    turbo_mode && div_cnt > 8'h31 |=> div_cnt == 8'h00) else $error("turbo rate");

  cov_good_frame: cover property (@(posedge ref_clk) disable iff (!nrst) rx_len_valid);
  cov_bad_frame:  cover property (@(posedge ref_clk) disable iff (!nrst) rx_drop);
  cov_warm_reset: cover property (@(posedge ref_clk) disable iff (!nrst)
    rst_st == rpfrc_pkg::RPF_WARM ##1 rst_st == rpfrc_pkg::RPF_RUN);
  cov_irq:        cover property (@(posedge ref_clk) disable iff (!nrst) $fell(irq_n));
endmodule : rpfrc_core
`default_nettype wire

// ---- sim/rpfrc_host_model.sv ----
// behavioural host: warm reset pin, spi select and interrupt acknowledge
`timescale 1ns/100ps
`default_nettype none
module rpfrc_host_model (
  input  wire logic ref_clk,
  input  wire logic ready,
  input  wire logic irq_n,
  input  wire logic warm_req,
  input  wire logic sel_req,
  input  wire logic ack_en,
  input  wire logic ack_slow,
  output logic      warm_rst_n_pin,
  output logic      serial_select_in,
  output logic      irq_ack
);
  int wait_cnt = 0;
  initial begin
    warm_rst_n_pin   = 1'b1;
    serial_select_in = 1'b1;
    irq_ack          = 1'b0;
  end
  // a released reset pin is driven high, standing in for its pull-up level
  always @(posedge ref_clk) warm_rst_n_pin <= ~warm_req;
  // never selects the radio while it still holds in reset
  always @(posedge ref_clk) serial_select_in <= ~(sel_req && ready);
  // slow mode lets the flag sit for a while before it is cleared
  always @(posedge ref_clk) begin
    irq_ack <= 1'b0;
    if (ack_en && irq_n === 1'b0 && !irq_ack) begin
      if (wait_cnt >= (ack_slow ? 8 : 0)) begin
        irq_ack  <= 1'b1;
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule // rpfrc_host_model
`default_nettype wire

// ---- sim/rpfrc_core_tb.sv ----
// self-checking bench for the phy framer core
`timescale 1ns/100ps
`default_nettype none
module rpfrc_core_tb;
  localparam int POR  = 200;
  localparam int WARM = 20;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        turbo_mode = 1'b0;
  logic        rx_bit_in = 1'b1;
  logic        wake_evt = 1'b0;
  logic        tx_done_evt = 1'b0;
  logic        tx_timeout_evt = 1'b0;
  logic        rx_ready = 1'b1;
  logic [6:0]  chan_sel = 7'h00;
  logic        warm_req = 1'b0;
  logic        sel_req = 1'b0;
  logic        ack_en = 1'b0;
  logic        ack_slow = 1'b0;
  wire logic   ready, spi_frame_active, sym_tick, rx_valid, rx_len_valid, rx_drop, irq_n;
  wire logic   warm_rst_n_pin, serial_select_in, irq_ack;
  wire logic [11:0] carrier_mhz;
  wire logic [3:0]  bandwidth_mhz;
  wire logic [7:0]  rx_data;
  wire logic [5:0]  rx_len;
  int          bad_count = 0;
  int          checks_done = 0;
  int          len_cnt = 0;
  int          drop_cnt = 0;
  int          seen_len = 0;
  logic [7:0]  got[$];
  logic [6:0]  chans[5] = '{7'h00, 7'h01, 7'h5f, 7'h60, 7'h7f};

  always #10 ref_clk = ~ref_clk;

  rpfrc_core #(.POR_CYC(POR), .WARM_CYC(WARM), .DEPTH(16)) u_dut (
    .ref_clk(ref_clk), .nrst(nrst), .warm_rst_n_pin(warm_rst_n_pin),
    .serial_select_in(serial_select_in), .turbo_mode(turbo_mode), .chan_sel(chan_sel),
    .rx_bit_in(rx_bit_in), .wake_evt(wake_evt), .tx_done_evt(tx_done_evt),
    .tx_timeout_evt(tx_timeout_evt), .irq_ack(irq_ack), .ready(ready),
    .spi_frame_active(spi_frame_active), .carrier_mhz(carrier_mhz),
    .bandwidth_mhz(bandwidth_mhz), .sym_tick(sym_tick), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_len(rx_len),
    .rx_len_valid(rx_len_valid), .rx_drop(rx_drop), .irq_n(irq_n));

  rpfrc_host_model u_host (
    .ref_clk(ref_clk), .ready(ready), .irq_n(irq_n), .warm_req(warm_req),
    .sel_req(sel_req), .ack_en(ack_en), .ack_slow(ack_slow),
    .warm_rst_n_pin(warm_rst_n_pin), .serial_select_in(serial_select_in), .irq_ack(irq_ack));

  // pulses last one cycle, so they are collected here rather than polled
  always @(posedge ref_clk) begin
    if (rx_len_valid === 1'b1) begin
      len_cnt++;
      seen_len = rx_len;
    end
    if (rx_drop === 1'b1) drop_cnt++;
    if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset();
    int n;
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (2) @(negedge ref_clk);
    check(ready, 0);
    check(irq_n, 1);
    check(carrier_mhz, rpfrc_pkg::CHAN_BASE_MHZ);
    @(posedge ref_clk) nrst <= 1'b1;
    repeat (POR - 10) @(negedge ref_clk);
    check(ready, 0);
    n = 0;
    while (ready !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check(ready, 1);
  endtask

  task automatic ack(input logic slow);
    int n;
    @(posedge ref_clk) begin
      ack_en   <= 1'b1;
      ack_slow <= slow;
    end
    n = 0;
    while (irq_n !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check(irq_n, 1);
    @(posedge ref_clk) ack_en <= 1'b0;
  endtask

  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (sym_tick !== 1'b1 && n < 400);
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      wait_tick();
      @(posedge ref_clk) rx_bit_in <= b[i];
    end
  endtask

  task automatic send_frame(input logic [7:0] dl, input logic [7:0] ln, input int n);
    len_cnt  = 0;
    drop_cnt = 0;
    got.delete();
    for (int i = 0; i < 4; i++) send_byte(rpfrc_pkg::PREAMBLE_BYTE);
    send_byte(dl);
    send_byte(ln);
    for (int i = 0; i < n; i++) send_byte(8'h10 + 8'(i));
    wait_tick();
    @(posedge ref_clk) rx_bit_in <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_sel();
    @(posedge ref_clk) sel_req <= 1'b1;
    repeat (6) @(negedge ref_clk);
    check(spi_frame_active, 1);
    @(posedge ref_clk) sel_req <= 1'b0;
    repeat (6) @(negedge ref_clk);
    check(spi_frame_active, 0);
  endtask

  task automatic t_warm();
    int n;
    @(posedge ref_clk) warm_req <= 1'b1;
    repeat (6) @(posedge ref_clk);
    wake_evt <= 1'b1;
    @(posedge ref_clk) wake_evt <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check(ready, 0);
    check(irq_n, 1);
    @(posedge ref_clk) warm_req <= 1'b0;
    repeat (WARM - 2) @(negedge ref_clk);
    check(ready, 0);
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    check(ready, 1);
  endtask

  task automatic t_evt();
    for (int e = 0; e < 3; e++) begin
      @(posedge ref_clk) begin
        wake_evt       <= (e == 0);
        tx_done_evt    <= (e == 1);
        tx_timeout_evt <= (e == 2);
      end
      @(posedge ref_clk) begin
        wake_evt       <= 1'b0;
        tx_done_evt    <= 1'b0;
        tx_timeout_evt <= 1'b0;
      end
      @(negedge ref_clk);
      check(irq_n, 0);
      repeat (5) @(negedge ref_clk);
      check(irq_n, 0);
      ack(e[0]);
    end
  endtask

  task automatic t_rate();
    int n;
    for (int t = 0; t < 2; t++) begin
      @(posedge ref_clk) turbo_mode <= t[0];
      repeat (4) @(negedge ref_clk);
      check(bandwidth_mhz, t ? rpfrc_pkg::TURBO_BW_MHZ : rpfrc_pkg::NORMAL_BW_MHZ);
      wait_tick();
      wait_tick();
      n = 0;
      do begin
        @(negedge ref_clk);
        n++;
      end while (sym_tick !== 1'b1 && n < 400);
      check(n, t ? rpfrc_pkg::RATE_DIV_TURB : rpfrc_pkg::RATE_DIV_NORM);
    end
  endtask

  task automatic t_chan();
    int exp;
    foreach (chans[i]) begin
      @(posedge ref_clk) chan_sel <= chans[i];
      repeat (3) @(negedge ref_clk);
      exp = (chans[i] > rpfrc_pkg::CHAN_MAX) ? rpfrc_pkg::CHAN_MAX : chans[i];
      check(carrier_mhz, rpfrc_pkg::CHAN_BASE_MHZ + exp);
    end
  endtask

  task automatic t_frame(input int len);
    send_frame(rpfrc_pkg::DELIM_BYTE, 8'(len), len);
    check(len_cnt, 1);
    check(seen_len, len);
    check(drop_cnt, 0);
    check(got.size(), len);
    foreach (got[i]) check(got[i], 8'h10 + 8'(i));
    check(irq_n, 0);
    ack(1'b0);
  endtask

  task automatic t_fill();
    @(posedge ref_clk) rx_ready <= 1'b0;
    send_frame(rpfrc_pkg::DELIM_BYTE, 8'h14, 20);
    check(drop_cnt > 0, 1);
    @(posedge ref_clk) rx_ready <= 1'b1;
    repeat (40) @(posedge ref_clk);
    check(got.size(), 16);
    check(got[0], 8'h10);
    check(got[15], 8'h1f);
    ack(1'b1);
  endtask

  // each dropped header is followed by a reset so a skip cannot swallow the next test
  task automatic t_bad(input logic [7:0] dl, input logic [7:0] ln, input int drops);
    send_frame(dl, ln, 0);
    check(len_cnt, 0);
    check(drop_cnt, drops);
    check(irq_n, 1);
    do_reset();
  endtask

  initial begin
    do_reset();
    t_sel();
    t_warm();
    t_evt();
    t_rate();
    t_chan();
    t_frame(7);
    t_frame(63);
    t_fill();
    t_bad(rpfrc_pkg::DELIM_BYTE ^ 8'h01, 8'h07, 0);
    t_bad(rpfrc_pkg::DELIM_BYTE, 8'h06, 1);
    t_bad(rpfrc_pkg::DELIM_BYTE, 8'h40, 1);
    stop_test();
  end

  initial begin
    #2_000_000;
    bad_count++;
    stop_test();
  end
endmodule // rpfrc_core_tb
`default_nettype wire
